// File: testbench.sv
// Self-checking bench for the two-channel PWM timer with a stage model.
// Assumes inputs change on the falling edge of a 200 MHz clock.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, three_output_pwm_select, ext_clock_input_enable;
    logic external_clock_pin, start_wr, level_wr, gr_wr, gr_ch;
    logic stat_rd, stat_wr, stat_ch, reset_sync_active, three_output_pwm_select_active, watch;
    logic [1:0] combination_mode_field, c_buffer_select, d_buffer_select;
    logic [1:0] ext_clock_edge_select, start_wdata, stop_sel_wdata, gr_sel;
    logic [1:0] count_running;
    logic [2:0] clock_source_select;
    logic [5:0] pwm_mode_select;
    logic [6:0] active_level, wave_out_enable, level_wdata, pwm_pin, hold;
    logic [6:0] done;
    logic [6:0][15:0] width;
    logic [7:0] stat_wdata, ch0_status_reg, ch1_status_reg;
    logic [15:0] gr_wdata, ch0_counter, ch1_counter, cnt;
    logic [15:0] exp_q [7][$];
    logic [31:0] seed = 32'h000138b0;
    int failures = 0;
    int n_tests = 0;
    // Per-pin widths for period 10 (A = 9), change points 3, 5 and 7
    localparam logic [15:0] W [7] = '{16'h6, 16'ha, 16'h4, 16'h2,
                                     16'h6, 16'h8, 16'h4};

    tpw_top dut_u (.clk, .rst_n, .combination_mode_field,
        .three_output_pwm_select, .pwm_mode_select, .c_buffer_select,
        .d_buffer_select, .active_level, .wave_out_enable,
        .clock_source_select, .ext_clock_input_enable,
        .ext_clock_edge_select, .external_clock_pin, .start_wr,
        .start_wdata, .stop_sel_wdata, .level_wr, .level_wdata, .gr_wr,
        .gr_ch, .gr_sel, .gr_wdata, .stat_rd, .stat_wr, .stat_ch,
        .stat_wdata, .pwm_pin, .ch0_status_reg, .ch1_status_reg,
        .ch0_counter, .ch1_counter, .count_running, .reset_sync_active,
        .three_output_pwm_select_active);
    tpw_stage_model stage_u (.clk, .rst_n, .watch, .pin(pwm_pin), .done,
        .width);

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic lvl(input logic [6:0] v);
        level_wdata = v;
        level_wr = 1'b1;
        cyc(1);
        level_wr = 1'b0;
        cyc(1);
    endtask

    task automatic gr(input logic ch, input logic [1:0] s, input int v);
        gr_ch = ch;
        gr_sel = s;
        gr_wdata = v[15:0];
        gr_wr = 1'b1;
        cyc(1);
        gr_wr = 1'b0;
        cyc(1);
    endtask

    task automatic st(input logic [1:0] s, input logic [1:0] sel);
        start_wdata = s;
        stop_sel_wdata = sel;
        start_wr = 1'b1;
        cyc(1);
        start_wr = 1'b0;
        cyc(1);
    endtask

    task automatic stat(input logic rd, input logic wr, input logic [7:0] d);
        stat_rd = rd;
        stat_wr = wr;
        stat_wdata = d;
        cyc(1);
        stat_rd = 1'b0;
        stat_wr = 1'b0;
        cyc(1);
    endtask

    task automatic toggle(input int n);
        repeat (n)
        begin
            external_clock_pin = ~external_clock_pin;
            cyc(2);
        end
    endtask

    // Stage reports are matched to the oldest width noted per pin
    always @(negedge clk)
        for (int i = 0; i < 7; i++)
            if (done[i] === 1'b1 && exp_q[i].size() > 0)
                check(width[i], exp_q[i].pop_front());

    initial
    begin
        #20000;
        failures++;
        end_sim();
    end

    initial
    begin
        {rst_n, three_output_pwm_select, ext_clock_input_enable} = 3'h0;
        {external_clock_pin, start_wr, level_wr, gr_wr, gr_ch} = 5'h00;
        {stat_rd, stat_wr, stat_ch, watch, cnt, hold} = 27'h0;
        {combination_mode_field, c_buffer_select, d_buffer_select} = 6'h00;
        {start_wdata, stop_sel_wdata, gr_sel, level_wdata} = 13'h0000;
        {pwm_mode_select, stat_wdata, gr_wdata} = 30'h0;
        ext_clock_edge_select = tpw_pkg::EDGE_FALL;
        clock_source_select = tpw_pkg::SRC_F1;
        active_level = 7'h7f;
        wave_out_enable = 7'h7f;
        cyc(6);
        rst_n = 1'b1;
        cyc(1);
        check(ch0_status_reg, 8'h20);
        for (int k = 0; k < 4; k++)
        begin
            lvl(7'(rnd() >> 3));
            check(pwm_pin, seed[9:3]);
        end
        lvl(7'h00);
        three_output_pwm_select = 1'b1;
        cyc(2);
        check(three_output_pwm_select_active, 1'b1);
        combination_mode_field = tpw_pkg::CMD_RESET_SYNC;
        gr(1'b0, 2'h0, 9);
        gr(1'b0, 2'h1, 3);
        gr(1'b1, 2'h0, 5);
        gr(1'b1, 2'h1, 7);
        check({reset_sync_active, three_output_pwm_select_active}, 2'h2);
        for (int k = 0; k < 14; k++)
            exp_q[k % 7].push_back(W[k % 7]);
        watch = 1'b1;
        st(2'h1, 2'h1);
        cyc(60);
        watch = 1'b0;
        st(2'h0, 2'h1);
        cyc(2);
        hold = pwm_pin;
        cnt = ch0_counter;
        cyc(10);
        check(pwm_pin, hold);
        check(ch0_counter, cnt);
        check(ch1_counter, 16'h0000);
        for (int i = 0; i < 7; i++)
            check(16'(exp_q[i].size()), 16'h0000);
        check(ch0_status_reg, 8'h23);
        check(ch1_status_reg, 8'h03);
        stat(1'b0, 1'b1, 8'h00);
        check(ch0_status_reg, 8'h23);
        stat(1'b1, 1'b0, 8'h00);
        stat(1'b0, 1'b1, 8'h1f);
        check(ch0_status_reg, 8'h23);
        stat(1'b0, 1'b1, 8'h00);
        check(ch0_status_reg, 8'h20);
        clock_source_select = tpw_pkg::SRC_EXT;
        st(2'h1, 2'h1);
        toggle(6);
        check(ch0_counter, cnt);
        ext_clock_input_enable = 1'b1;
        ext_clock_edge_select = tpw_pkg::EDGE_RISE;
        toggle(6);
        cyc(3);
        st(2'h0, 2'h1);
        check(ch0_counter, (cnt + 16'h0003) % 16'h000a);
        clock_source_select = tpw_pkg::SRC_F1;
        st(2'h1, 2'h0);
        for (int k = 0; k < 40 && count_running[0] !== 1'b0; k++)
            cyc(1);
        cyc(5);
        check(count_running, 2'h0);
        check(ch0_counter, 16'h0000);
        check({pwm_pin[6], pwm_pin[3], pwm_pin[0]}, 3'h0);
        check({pwm_pin[5], pwm_pin[4], pwm_pin[2]}, 3'h7);
        // Plain PWM on B0 with C and D of channel 0 as buffers
        combination_mode_field = tpw_pkg::CMD_TIMER;
        {three_output_pwm_select, pwm_mode_select} = 7'h01;
        {c_buffer_select, d_buffer_select} = 4'h5;
        gr(1'b0, 2'h2, 9);
        gr(1'b0, 2'h3, 5);
        exp_q[0].push_back(16'h0006);
        exp_q[0].push_back(16'h0004);
        watch = 1'b1;
        st(2'h1, 2'h1);
        cyc(25);
        check(16'(exp_q[0].size()), 16'h0000);
        check(ch0_status_reg, 8'h2f);
        end_sim();
    end
endmodule

`default_nettype wire

// File: tpw_count_src.sv
// Count source: prescaled clocks, 40 MHz oscillator tick and the
// external clock pin edge, reduced to a one-cycle count tick.
// Assumes ext_pin is synchronous to clk.
`default_nettype none

module tpw_count_src (
    input wire logic clk, // System clock
    input wire logic rst_n, // Sync reset, active low
    input wire logic [2:0] clock_source_select, // Count source
    input wire logic ext_clock_input_enable, // External clock on
    input wire logic [1:0] ext_clock_edge_select, // Valid edge
    input wire logic external_clock_pin, // External clock level
    tpw_tick_if.src tick_if // Count tick out
);

    logic [4:0] pre;
    logic [2:0] osc;
    logic ext_prev;
    logic ext_tick;
    logic next_tick;

    // ------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pre <= 5'h00;
        else
            pre <= pre + 5'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            osc <= 3'h0;
        else if (osc == 3'(tpw_pkg::OSC_DIV - 1))
            osc <= 3'h0;
        else
            osc <= osc + 3'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ext_prev <= 1'b0;
        else
            ext_prev <= external_clock_pin;
    end

    // ------------------------------------------------------------
    // Source select
    // ------------------------------------------------------------
    always_comb
    begin
        // Edge choice only counts with the pin enabled as a clock
        ext_tick = 1'b0;
        if (ext_clock_input_enable)
        begin
            if (ext_clock_edge_select == tpw_pkg::EDGE_RISE)
                ext_tick = external_clock_pin & ~ext_prev;
            else if (ext_clock_edge_select == tpw_pkg::EDGE_FALL)
                ext_tick = ~external_clock_pin & ext_prev;
            else
                ext_tick = external_clock_pin ^ ext_prev;
        end
    end

    always_comb
    begin
        unique case (clock_source_select)
            tpw_pkg::SRC_F1: next_tick = 1'b1;
            tpw_pkg::SRC_F2: next_tick = pre[0];
            tpw_pkg::SRC_F4: next_tick = &pre[1:0];
            tpw_pkg::SRC_F8: next_tick = &pre[2:0];
            tpw_pkg::SRC_F32: next_tick = &pre;
            tpw_pkg::SRC_EXT: next_tick = ext_tick;
            tpw_pkg::SRC_OSC: next_tick = (osc == 3'h0);
            default: next_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            tick_if.tick <= 1'b0;
        else
            tick_if.tick <= next_tick;
    end

    a_ext_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (clock_source_select == tpw_pkg::SRC_EXT && !ext_clock_input_enable)
        |=> !tick_if.tick)
        else $error("external tick without clock enable");

endmodule

`default_nettype wire

// File: tpw_pkg.sv
// Shared constants for the timer PWM block: count sources, modes,
// pin slots, status flag layout and clock-rate derived counts.
// Assumes a single 200 MHz system clock.
`default_nettype none

package tpw_pkg;

    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] GR_RST = 16'hffff;

    // ------------------------------------------------------------
    // Count source select codes
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_F1 = 3'h0;
    localparam logic [2:0] SRC_F2 = 3'h1;
    localparam logic [2:0] SRC_F4 = 3'h2;
    localparam logic [2:0] SRC_F8 = 3'h3;
    localparam logic [2:0] SRC_F32 = 3'h4;
    localparam logic [2:0] SRC_EXT = 3'h5;
    localparam logic [2:0] SRC_OSC = 3'h6;

    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    // ------------------------------------------------------------
    // Combination mode codes
    // ------------------------------------------------------------
    localparam logic [1:0] CMD_TIMER = 2'h0;
    localparam logic [1:0] CMD_RESET_SYNC = 2'h1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int OSC_PERIOD_NS = 25;
    localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // General register slots and pin slots
    // ------------------------------------------------------------
    localparam int GR_A = 0;
    localparam int GR_B = 1;
    localparam int GR_C = 2;
    localparam int GR_D = 3;

    localparam int PIN_B0 = 0;
    localparam int PIN_C0 = 1;
    localparam int PIN_D0 = 2;
    localparam int PIN_B1 = 3;
    localparam int PIN_C1 = 4;
    localparam int PIN_D1 = 5;
    localparam int PIN_A1 = 6;
    localparam logic [6:0] PIN_RST = 7'h00;

    // ------------------------------------------------------------
    // Status register layout
    // ------------------------------------------------------------
    localparam int FLG_OVF = 4;
    localparam int STAT_RSVD_BIT = 5;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic STAT_B5_VAL = 1'b1;

endpackage

`default_nettype wire

// File: tpw_stage_model.sv
// Power stage model: measures how long each pin stays at its high level.
// Assumes the pins are registered on clk and only driven by the timer.
`default_nettype none

module tpw_stage_model (
    input wire logic clk, // System clock
    input wire logic rst_n, // Sync reset, active low
    input wire logic watch, // Report ended pulses when high
    input wire logic [6:0] pin, // Timer pins B0 C0 D0 B1 C1 D1 A1
    output logic [6:0] done, // High pulse ended on this pin
    output logic [6:0][15:0] width // Cycles the ended pulse lasted
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0][15:0] run;
    logic [6:0] prev;

    // Stage only sees levels; a stopped timer simply yields no edges
    always_ff @(posedge clk)
    begin
        prev <= rst_n ? pin : 7'h00;
        for (int i = 0; i < 7; i++)
        begin
            run[i] <= (rst_n && pin[i]) ? run[i] + 16'h0001 : 16'h0000;
            done[i] <= rst_n && watch && prev[i] && !pin[i];
            width[i] <= run[i];
        end
    end
endmodule

`default_nettype wire

// File: tpw_tick_if.sv
// Count-enable tick passed from the count source to the counters.
// Assumes both ends share the system clock.
`default_nettype none

interface tpw_tick_if;
    logic tick;
    modport src (output tick);
    modport sink (input tick);
endinterface

`default_nettype wire

// File: tpw_top.sv
// Two-channel PWM timer: plain PWM per pin and reset synchronous
// three-phase PWM. Control and status travel on plain ports.
// Assumes all inputs synchronous to clk; software strobes one cycle.
//
// What this block does
// - Three-output select only counts when mode 00
// - Level write drives waveform pins immediately
// - Edge select needs external source and enable
// - Channel 0 status bit 5 reads one
// - Flag clears by zero after reading one
// - C/D match flags set even when buffering
// - Filter and capture controls ignored in PWM
// - A sets period, B sets B change
// - Unbuffered C/D set their pin change point
// - Buffered C holds next period, D next B
// - Reset sync: three phases plus complements
// - Five dividers, oscillator or external pin
// - Reset sync counts channel 0 only
// - Period m+1, widths m-n and n+1
// - Reset sync period and change registers mapping
// - Writing start one begins counting
// - Stop-select one: stop holds levels
// - Stop-select zero: stop at period match
// - Nonzero mode overrides per-pin PWM select
// - Reset sync: channel 0 C pin toggles each period
// - Match and overflow events raise flags
`default_nettype none

module tpw_top (
    input wire logic clk, // System clock
    input wire logic rst_n, // Sync reset, active low
    input wire logic [1:0] combination_mode_field, // Mode field
    input wire logic three_output_pwm_select, // Three-output mode
    input wire logic [5:0] pwm_mode_select, // Per-pin PWM enable
    input wire logic [1:0] c_buffer_select, // C as buffer, per ch
    input wire logic [1:0] d_buffer_select, // D as buffer, per ch
    input wire logic [6:0] active_level, // Active level per pin
    input wire logic [6:0] wave_out_enable, // Pin is waveform out
    input wire logic [2:0] clock_source_select, // Count source
    input wire logic ext_clock_input_enable, // External clock on
    input wire logic [1:0] ext_clock_edge_select, // Valid edge
    input wire logic external_clock_pin, // External clock pin
    input wire logic start_wr, // Start control write
    input wire logic [1:0] start_wdata, // New count-start bits
    input wire logic [1:0] stop_sel_wdata, // New stop-select bits
    input wire logic level_wr, // Output-level control write
    input wire logic [6:0] level_wdata, // Initial pin levels
    input wire logic gr_wr, // General register write
    input wire logic gr_ch, // Channel of the write
    input wire logic [1:0] gr_sel, // A, B, C or D
    input wire logic [15:0] gr_wdata, // Value written
    input wire logic stat_rd, // Status register read
    input wire logic stat_wr, // Status register write
    input wire logic stat_ch, // Channel of status access
    input wire logic [7:0] stat_wdata, // Status write data
    output logic [6:0] pwm_pin, // Pins B0 C0 D0 B1 C1 D1 A1
    output logic [7:0] ch0_status_reg, // Channel 0 status
    output logic [7:0] ch1_status_reg, // Channel 1 status
    output logic [15:0] ch0_counter, // Channel 0 count
    output logic [15:0] ch1_counter, // Channel 1 count
    output logic [1:0] count_running, // Count-start bits
    output logic reset_sync_active, // Reset sync mode decoded
    output logic three_output_pwm_select_active // Three-output mode decoded
);

    tpw_tick_if tick_if ();

    logic [15:0] cnt [2];
    logic [15:0] gr [2][4];
    logic [1:0] start;
    logic [1:0] stop_sel;
    logic [4:0] flags [2];
    logic [4:0] snap [2];
    logic stat_b5;
    logic [6:0] pin;
    logic rsm;
    logic pwm_plain;
    logic [1:0] run_tick;
    logic [3:0] mt [2];
    logic [1:0] ovf;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] b,
                                 input logic en);
        hit = en && (a == b);
    endfunction

    tpw_count_src u_src (
        .clk(clk),
        .rst_n(rst_n),
        .clock_source_select(clock_source_select),
        .ext_clock_input_enable(ext_clock_input_enable),
        .ext_clock_edge_select(ext_clock_edge_select),
        .external_clock_pin(external_clock_pin),
        .tick_if(tick_if.src)
    );

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // No filter or capture controls exist here, so PWM ignores them
    always_comb
    begin
        rsm = (combination_mode_field == tpw_pkg::CMD_RESET_SYNC);
        pwm_plain = (combination_mode_field == tpw_pkg::CMD_TIMER)
                    && !three_output_pwm_select;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            three_output_pwm_select_active <= 1'b0;
        else
            three_output_pwm_select_active <= three_output_pwm_select
                && combination_mode_field == tpw_pkg::CMD_TIMER;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            reset_sync_active <= 1'b0;
        else
            reset_sync_active <= rsm;
    end

    // ------------------------------------------------------------
    // Match events
    // ------------------------------------------------------------
    always_comb
    begin
        run_tick[0] = start[0] && tick_if.tick;
        run_tick[1] = start[1] && tick_if.tick && !rsm;
        for (int c = 0; c < 2; c++)
        begin
            for (int k = 0; k < 4; k++)
                mt[c][k] = hit(cnt[c], gr[c][k], run_tick[c]);
            ovf[c] = run_tick[c] && cnt[c] == tpw_pkg::CNT_MAX
                     && !mt[c][tpw_pkg::GR_A];
        end
        // Channel 1 A and B compare against the channel 0 count
        if (rsm)
        begin
            mt[1][tpw_pkg::GR_A] = hit(cnt[0], gr[1][tpw_pkg::GR_A],
                                       run_tick[0]);
            mt[1][tpw_pkg::GR_B] = hit(cnt[0], gr[1][tpw_pkg::GR_B],
                                       run_tick[0]);
        end
    end

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (!rst_n)
                cnt[c] <= tpw_pkg::CNT_RST;
            else if (run_tick[c] && mt[c][tpw_pkg::GR_A])
                cnt[c] <= tpw_pkg::CNT_RST;
            else if (run_tick[c])
                cnt[c] <= cnt[c] + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Start and stop
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            start <= 2'h0;
            stop_sel <= 2'h0;
        end
        else if (start_wr)
        begin
            // A stop by write leaves every pin where it was
            start <= start_wdata;
            stop_sel <= stop_sel_wdata;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
                if (mt[c][tpw_pkg::GR_A] && !stop_sel[c])
                    start[c] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // General registers with buffer transfer at period match
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        for (int c = 0; c < 2; c++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (!rst_n)
                    gr[c][k] <= tpw_pkg::GR_RST;
                else if (gr_wr && gr_ch == 1'(c) && gr_sel == 2'(k))
                    gr[c][k] <= gr_wdata;
                else if (mt[c][tpw_pkg::GR_A] && k == tpw_pkg::GR_A
                         && c_buffer_select[c])
                    gr[c][k] <= gr[c][tpw_pkg::GR_C];
                else if (mt[c][tpw_pkg::GR_A] && k == tpw_pkg::GR_B
                         && d_buffer_select[c])
                    gr[c][k] <= gr[c][tpw_pkg::GR_D];
            end
        end
    end

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    // Change points first, period last: with n equal to m the
    // normal phase must get no active width at all.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pin <= tpw_pkg::PIN_RST;
        else if (level_wr)
        begin
            for (int p = 0; p < 7; p++)
                if (wave_out_enable[p])
                    pin[p] <= level_wdata[p];
        end
        else if (rsm)
        begin
            if (mt[0][tpw_pkg::GR_B])
            begin
                pin[tpw_pkg::PIN_B0] <= active_level[tpw_pkg::PIN_B0];
                pin[tpw_pkg::PIN_D0] <= ~active_level[tpw_pkg::PIN_D0];
            end
            if (mt[1][tpw_pkg::GR_A])
            begin
                pin[tpw_pkg::PIN_A1] <= active_level[tpw_pkg::PIN_A1];
                pin[tpw_pkg::PIN_C1] <= ~active_level[tpw_pkg::PIN_C1];
            end
            if (mt[1][tpw_pkg::GR_B])
            begin
                pin[tpw_pkg::PIN_B1] <= active_level[tpw_pkg::PIN_B1];
                pin[tpw_pkg::PIN_D1] <= ~active_level[tpw_pkg::PIN_D1];
            end
            if (mt[0][tpw_pkg::GR_A])
            begin
                pin[tpw_pkg::PIN_B0] <= ~active_level[tpw_pkg::PIN_B0];
                pin[tpw_pkg::PIN_D0] <= active_level[tpw_pkg::PIN_D0];
                pin[tpw_pkg::PIN_A1] <= ~active_level[tpw_pkg::PIN_A1];
                pin[tpw_pkg::PIN_C1] <= active_level[tpw_pkg::PIN_C1];
                pin[tpw_pkg::PIN_B1] <= ~active_level[tpw_pkg::PIN_B1];
                pin[tpw_pkg::PIN_D1] <= active_level[tpw_pkg::PIN_D1];
                pin[tpw_pkg::PIN_C0] <= ~pin[tpw_pkg::PIN_C0];
            end
        end
        else if (pwm_plain)
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (mt[c][tpw_pkg::GR_B] && pwm_mode_select[3*c])
                    pin[3*c] <= active_level[3*c];
                if (mt[c][tpw_pkg::GR_C] && !c_buffer_select[c]
                    && pwm_mode_select[3*c+1])
                    pin[3*c+1] <= active_level[3*c+1];
                if (mt[c][tpw_pkg::GR_D] && !d_buffer_select[c]
                    && pwm_mode_select[3*c+2])
                    pin[3*c+2] <= active_level[3*c+2];
                if (mt[c][tpw_pkg::GR_A])
                    for (int j = 0; j < 3; j++)
                        if (pwm_mode_select[3*c+j]
                            && (j != 1 || !c_buffer_select[c])
                            && (j != 2 || !d_buffer_select[c]))
                            pin[3*c+j] <= ~active_level[3*c+j];
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Read snapshot decides which bits a zero write may clear, so
    // an event landing after the read survives the clearing write.
    always_ff @(posedge clk)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (!rst_n)
            begin
                flags[c] <= tpw_pkg::FLAGS_RST;
                snap[c] <= tpw_pkg::FLAGS_RST;
            end
            else
            begin
                if (stat_wr && stat_ch == 1'(c))
                    flags[c] <= (flags[c] & ~(~stat_wdata[4:0] & snap[c]))
                                | {ovf[c], mt[c]};
                else
                    flags[c] <= flags[c] | {ovf[c], mt[c]};
                if (stat_rd && stat_ch == 1'(c))
                    snap[c] <= flags[c];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            stat_b5 <= tpw_pkg::STAT_B5_VAL;
        else
            stat_b5 <= tpw_pkg::STAT_B5_VAL;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pwm_pin = pin;
    assign ch0_status_reg = {2'h0, stat_b5, flags[0]};
    assign ch1_status_reg = {3'h0, flags[1]};
    assign ch0_counter = cnt[0];
    assign ch1_counter = cnt[1];
    assign count_running = start;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_ch1_idle_rsm: assert property (@(posedge clk) disable iff (!rst_n)
        rsm |=> cnt[1] == $past(cnt[1]))
        else $error("channel 1 counted in reset sync mode");

    a_period_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        mt[0][tpw_pkg::GR_A] |=> cnt[0] == tpw_pkg::CNT_RST)
        else $error("counter did not clear at period match");

    a_stop_match: assert property (@(posedge clk) disable iff (!rst_n)
        mt[0][tpw_pkg::GR_A] && !stop_sel[0] && !start_wr |=> !start[0])
        else $error("count did not stop at period match");

    a_b5_one: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 ch0_status_reg[tpw_pkg::STAT_RSVD_BIT])
        else $error("status bit 5 not one");

    a_buf_flag: assert property (@(posedge clk) disable iff (!rst_n)
        mt[0][tpw_pkg::GR_C] |=> ch0_status_reg[tpw_pkg::GR_C])
        else $error("C match flag not set");

    a_clear_rule: assert property (@(posedge clk) disable iff (!rst_n)
        stat_wr && !stat_ch && stat_wdata[0] && ch0_status_reg[0]
        |=> ch0_status_reg[0])
        else $error("flag cleared by writing one");

    a_level_write: assert property (@(posedge clk) disable iff (!rst_n)
        level_wr && wave_out_enable[tpw_pkg::PIN_B0]
        |=> pwm_pin[tpw_pkg::PIN_B0] == $past(level_wdata[tpw_pkg::PIN_B0]))
        else $error("initial level not driven");

    a_c0_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        rsm && mt[0][tpw_pkg::GR_A] && !level_wr
        |=> pwm_pin[tpw_pkg::PIN_C0] != $past(pwm_pin[tpw_pkg::PIN_C0]))
        else $error("C0 did not toggle at period");

    a_three_output_pwm_select_gate: assert property (@(posedge clk) disable iff (!rst_n)
        combination_mode_field != tpw_pkg::CMD_TIMER |=> !three_output_pwm_select_active)
        else $error("three-output mode outside mode 00");

    a_buf_period: assert property (@(posedge clk) disable iff (!rst_n)
        mt[0][tpw_pkg::GR_A] && c_buffer_select[0] && !gr_wr
        |=> gr[0][tpw_pkg::GR_A] == $past(gr[0][tpw_pkg::GR_C]))
        else $error("buffered period not transferred");

endmodule

`default_nettype wire
